/* fcd_pkg.sv */
/*
 * fcd_pkg: constants and carrier types for the flash command host.
 * assumes: one 100 MHz clock; the flash is a parallel nor part outside the chip.
 */
package fcd_pkg;
  // bus widths
  localparam int FCD_AW = 18;
  localparam int FCD_DW = 16;
  // unlock addresses, word and byte mode
  localparam logic [17:0] FCD_UNL1_W = 18'h0_0555;
  localparam logic [17:0] FCD_UNL2_W = 18'h0_02AA;
  localparam logic [17:0] FCD_UNL1_B = 18'h0_0AAA;
  localparam logic [17:0] FCD_UNL2_B = 18'h0_0555;
  // autoselect offsets
  localparam logic [17:0] FCD_AS_MAKER = 18'h0_0000;
  localparam logic [17:0] FCD_AS_DEV_W = 18'h0_0001;
  localparam logic [17:0] FCD_AS_DEV_B = 18'h0_0002;
  localparam logic [17:0] FCD_AS_PROT_W = 18'h0_0002;
  localparam logic [17:0] FCD_AS_PROT_B = 18'h0_0004;
  // data codes
  localparam logic [7:0] FCD_D_AA = 8'hAA;
  localparam logic [7:0] FCD_D_55 = 8'h55;
  localparam logic [7:0] FCD_D_RESET = 8'hF0;
  localparam logic [7:0] FCD_D_ASEL = 8'h90;
  localparam logic [7:0] FCD_D_PROG = 8'hA0;
  localparam logic [7:0] FCD_D_BYP = 8'h20;
  localparam logic [7:0] FCD_D_BYPX = 8'h00;
  localparam logic [7:0] FCD_D_ESET = 8'h80;
  localparam logic [7:0] FCD_D_CERS = 8'h10;
  localparam logic [7:0] FCD_D_SERS = 8'h30;
  localparam logic [7:0] FCD_D_SUSP = 8'hB0;
  localparam logic [7:0] FCD_D_RESUME = 8'h30;
  // bus cycle timing, ns and derived cycles (least times round up)
  localparam int FCD_CLK_NS = 10;
  localparam int FCD_T_SETUP_NS = 30;
  localparam int FCD_T_PULSE_NS = 35;
  localparam int FCD_T_ACC_NS = 70;
  localparam int FCD_SETUP_CYC = (FCD_T_SETUP_NS + FCD_CLK_NS - 1) / FCD_CLK_NS;
  localparam int FCD_PULSE_CYC = (FCD_T_PULSE_NS + FCD_CLK_NS - 1) / FCD_CLK_NS;
  localparam int FCD_ACC_CYC = (FCD_T_ACC_NS + FCD_CLK_NS - 1) / FCD_CLK_NS;
  localparam logic [3:0] FCD_CNT_ZERO = 4'h0;

  // host command opcodes
  typedef enum logic [3:0] {
    FCD_OP_READ = 4'h0,
    FCD_OP_RESET = 4'h1,
    FCD_OP_ASEL = 4'h2,
    FCD_OP_PROG = 4'h3,
    FCD_OP_BYP_ENTER = 4'h4,
    FCD_OP_BYP_PROG = 4'h5,
    FCD_OP_BYP_EXIT = 4'h6,
    FCD_OP_CHIP_ERASE = 4'h7,
    FCD_OP_SECT_ERASE = 4'h8,
    FCD_OP_SUSPEND = 4'h9,
    FCD_OP_RESUME = 4'hA
  } fcd_op_t;

  // one request from the user side
  typedef struct packed {
    fcd_op_t op;
    logic [17:0] addr;
    logic [15:0] data;
  } fcd_req_t;

  // flash pins driven by the host
  typedef struct packed {
    logic ce_b;
    logic oe_b;
    logic we_b;
    logic reset_b;
    logic byte_b;
    logic [17:0] addr;
    logic [15:0] dq_o;
    logic dq_oe;
  } fcd_pins_t;
endpackage

/* fcd_host.sv */
/*
 * fcd_host: host-side sequencer that turns one user request into the
 * write/read bus cycles a parallel nor flash decodes as a command.
 * assumes: flash pins are sampled synchronously to i_mclk; dq is split into
 * in/out/enable and resolved outside; busy status is read back by software.
 */
// Functional notes
// - command cycles are host writes except reads
// - unlock addresses 555/2AA word, AAA/555 byte
// - reset is one F0 write anywhere
// - program: two unlocks, A0, address and data
// - bypass entry 20; bypass program A0 then data
// - bypass exit is 90 then 00
// - erase: six writes, 10 or 30 last
module fcd_host
  import fcd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // user request
  input wire logic i_req_valid,
  input wire fcd_req_t i_req,
  input wire logic i_byte_mode,
  input wire logic i_erasing,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output logic o_in_bypass,
  output logic o_in_suspend,
  // flash pins
  input wire logic [15:0] i_dq,
  output fcd_pins_t o_pins
);

  ////////////////////////////////////////////////////////////////////////////
  // state encoding
  typedef enum logic [3:0] {
    FCD_S_IDLE = 4'b0001,
    FCD_S_SETUP = 4'b0010,
    FCD_S_PULSE = 4'b0100,
    FCD_S_HOLD = 4'b1000
  } fcd_state_t;

  // one cycle of a sequence: address, data, and read or write
  typedef struct packed {
    logic rd;
    logic [17:0] addr;
    logic [7:0] data;
  } fcd_cyc_t;

  fcd_state_t state_q, state_d; // bus cycle phase
  fcd_req_t req_q, req_d; // request being run
  logic [2:0] idx_q, idx_d; // cycle index within sequence
  logic [3:0] cnt_q, cnt_d; // phase timer
  logic byp_q, byp_d; // unlock bypass mode held
  logic susp_q, susp_d; // erase suspended
  logic rdv_q, rdv_d; // read data valid pulse
  logic [15:0] rdd_q, rdd_d; // captured read data
  fcd_cyc_t cur, nxt; // present cycle decode, and the one the pins move to
  logic [2:0] len; // cycles in present sequence
  logic accept; // request legal in present mode

  ////////////////////////////////////////////////////////////////////////////
  // sequence table: cycle n of an operation
  function automatic fcd_cyc_t seq_cyc(input fcd_req_t r, input logic [2:0] n,
                                       input logic bm);
    logic [17:0] u1;
    logic [17:0] u2;
    fcd_cyc_t c;
    u1 = bm ? FCD_UNL1_B : FCD_UNL1_W;
    u2 = bm ? FCD_UNL2_B : FCD_UNL2_W;
    c = '{rd: 1'b0, addr: u1, data: FCD_D_AA};
    // cycles 0..1 and 3..4 form unlock pairs
    if (n == 3'd1 || n == 3'd4) begin
      c.addr = u2;
      c.data = FCD_D_55;
    end
    unique case (r.op)
      FCD_OP_READ: c = '{rd: 1'b1, addr: r.addr, data: 8'h00};
      FCD_OP_RESET: c = '{rd: 1'b0, addr: r.addr, data: FCD_D_RESET};
      FCD_OP_SUSPEND: c = '{rd: 1'b0, addr: r.addr, data: FCD_D_SUSP};
      FCD_OP_RESUME: c = '{rd: 1'b0, addr: r.addr, data: FCD_D_RESUME};
      FCD_OP_ASEL: begin
        if (n == 3'd2) c.data = FCD_D_ASEL;
        if (n == 3'd3) c = '{rd: 1'b1, addr: r.addr, data: 8'h00};
      end
      FCD_OP_PROG: begin
        if (n == 3'd2) c.data = FCD_D_PROG;
        if (n == 3'd3) c = '{rd: 1'b0, addr: r.addr, data: r.data[7:0]};
      end
      FCD_OP_BYP_ENTER: begin
        if (n == 3'd2) c.data = FCD_D_BYP;
      end
      FCD_OP_BYP_PROG: begin
        c = '{rd: 1'b0, addr: r.addr, data: FCD_D_PROG};
        if (n == 3'd1) c.data = r.data[7:0];
      end
      FCD_OP_BYP_EXIT: begin
        c = '{rd: 1'b0, addr: r.addr, data: FCD_D_ASEL};
        if (n == 3'd1) c.data = FCD_D_BYPX;
      end
      FCD_OP_CHIP_ERASE, FCD_OP_SECT_ERASE: begin
        if (n == 3'd2) c.data = FCD_D_ESET;
        if (n == 3'd5 && r.op == FCD_OP_CHIP_ERASE) c.data = FCD_D_CERS;
        if (n == 3'd5 && r.op == FCD_OP_SECT_ERASE) begin
          c.addr = {r.addr[17:12], 12'h000};
          c.data = FCD_D_SERS;
        end
      end
      default: c = '{rd: 1'b1, addr: r.addr, data: 8'h00};
    endcase
    return c;
  endfunction

  // number of bus cycles per operation
  function automatic logic [2:0] seq_len(input fcd_op_t op);
    unique case (op)
      FCD_OP_ASEL, FCD_OP_PROG: seq_len = 3'd4;
      FCD_OP_BYP_ENTER: seq_len = 3'd3;
      FCD_OP_BYP_PROG, FCD_OP_BYP_EXIT: seq_len = 3'd2;
      FCD_OP_CHIP_ERASE, FCD_OP_SECT_ERASE: seq_len = 3'd6;
      default: seq_len = 3'd1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode filter: a request not legal in the present mode is dropped
  always_comb begin
    accept = 1'b1;
    if (byp_q) begin
      // bypass only allows its own program and exit, and reads
      accept = (i_req.op == FCD_OP_BYP_PROG) || (i_req.op == FCD_OP_BYP_EXIT) ||
               (i_req.op == FCD_OP_READ);
    end else if (i_erasing) begin
      // running erase accepts only suspend and status reads
      accept = (i_req.op == FCD_OP_SUSPEND) || (i_req.op == FCD_OP_READ);
    end else if (susp_q) begin
      accept = !(i_req.op inside {FCD_OP_CHIP_ERASE, FCD_OP_SECT_ERASE, FCD_OP_BYP_ENTER,
               FCD_OP_BYP_PROG, FCD_OP_BYP_EXIT, FCD_OP_SUSPEND});
    end else begin
      accept = !(i_req.op inside {FCD_OP_BYP_PROG, FCD_OP_BYP_EXIT, FCD_OP_RESUME,
               FCD_OP_SUSPEND});
    end
  end

  assign cur = seq_cyc(req_q, idx_q, i_byte_mode);
  assign nxt = seq_cyc(req_d, idx_d, i_byte_mode);
  assign len = seq_len(req_q.op);
  assign o_req_ready = (state_q == FCD_S_IDLE) && i_ce;

  ////////////////////////////////////////////////////////////////////////////
  // next state: setup, strobe pulse, hold per bus cycle
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    byp_d = byp_q;
    susp_d = susp_q;
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    unique case (state_q)
      FCD_S_IDLE: begin
        // illegal requests are consumed silently, nothing reaches the pins
        if (i_req_valid && accept) begin
          req_d = i_req;
          idx_d = 3'd0;
          cnt_d = 4'(FCD_SETUP_CYC);
          state_d = FCD_S_SETUP;
        end
      end
      FCD_S_SETUP: begin
        // address stable before strobe falls
        if (cnt_q == FCD_CNT_ZERO) begin
          cnt_d = cur.rd ? 4'(FCD_ACC_CYC) : 4'(FCD_PULSE_CYC);
          state_d = FCD_S_PULSE;
        end else begin
          cnt_d = cnt_q - 4'd1;
        end
      end
      FCD_S_PULSE: begin
        if (cnt_q == FCD_CNT_ZERO) begin
          if (cur.rd) begin
            rdd_d = i_dq;
            rdv_d = 1'b1;
          end
          cnt_d = 4'(FCD_SETUP_CYC);
          state_d = FCD_S_HOLD;
        end else begin
          cnt_d = cnt_q - 4'd1;
        end
      end
      FCD_S_HOLD: begin
        // data held after strobe rises so the flash latches it
        if (cnt_q == FCD_CNT_ZERO) begin
          if (idx_q == len - 3'd1) begin
            state_d = FCD_S_IDLE;
            unique case (req_q.op)
              FCD_OP_BYP_ENTER: byp_d = 1'b1;
              FCD_OP_BYP_EXIT: byp_d = 1'b0;
              FCD_OP_SUSPEND: susp_d = 1'b1;
              FCD_OP_RESUME: susp_d = 1'b0;
              FCD_OP_RESET: byp_d = byp_q;
              default: susp_d = susp_q;
            endcase
          end else begin
            idx_d = idx_q + 3'd1;
            cnt_d = 4'(FCD_SETUP_CYC);
            state_d = FCD_S_SETUP;
          end
        end else begin
          cnt_d = cnt_q - 4'd1;
        end
      end
    endcase
  end

  // registers; the clock enable freezes everything
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= FCD_S_IDLE;
      req_q <= '0;
      idx_q <= 3'd0;
      cnt_q <= FCD_CNT_ZERO;
      byp_q <= 1'b0;
      susp_q <= 1'b0;
      rdv_q <= 1'b0;
      rdd_q <= 16'h0000;
    end else if (i_ce) begin
      state_q <= state_d;
      req_q <= req_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      byp_q <= byp_d;
      susp_q <= susp_d;
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs, registered
  fcd_pins_t pins_q, pins_d;
  logic rst_pin_q; // device reset released two edges after host reset

  always_comb begin
    pins_d = pins_q;
    pins_d.reset_b = rst_pin_q;
    pins_d.byte_b = ~i_byte_mode;
    if (state_d == FCD_S_IDLE) begin
      pins_d.ce_b = 1'b1;
      pins_d.oe_b = 1'b1;
      pins_d.we_b = 1'b1;
      pins_d.dq_oe = 1'b0;
    end else begin
      pins_d.ce_b = 1'b0;
      pins_d.addr = nxt.addr;
      pins_d.dq_o = {8'h00, nxt.data};
      if (req_d.op == FCD_OP_PROG && idx_d == 3'd3) pins_d.dq_o = req_d.data;
      if (req_d.op == FCD_OP_BYP_PROG && idx_d == 3'd1) pins_d.dq_o = req_d.data;
      pins_d.dq_oe = ~nxt.rd;
      pins_d.we_b = ~((state_d == FCD_S_PULSE) && !nxt.rd);
      pins_d.oe_b = ~((state_d == FCD_S_PULSE) && nxt.rd);
    end
  end

  // pins and reset pin registers
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pins_q <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, reset_b: 1'b0, byte_b: 1'b1,
                  addr: '0, dq_o: '0, dq_oe: 1'b0};
      rst_pin_q <= 1'b0;
    end else if (i_ce) begin
      pins_q <= pins_d;
      rst_pin_q <= 1'b1;
    end
  end

  assign o_pins = pins_q;
  assign o_rd_valid = rdv_q;
  assign o_rd_data = rdd_q;
  assign o_in_bypass = byp_q;
  assign o_in_suspend = susp_q;
endmodule

/* fcd_host_asserts.sv */
/* fcd_host_asserts: bus-cycle checks on the flash pins driven by fcd_host.
   assumes: bound into fcd_host; the bench holds i_ce high. */
module fcd_host_asserts
  import fcd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // watched ports
  input wire logic i_byte_mode,
  input wire fcd_pins_t o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////
  // a read and a write strobe together would corrupt the command
  a_strobe_excl: assert property (o_pins.we_b || o_pins.oe_b)
    else $error("write and read strobes low together");
  a_write_drive: assert property (!o_pins.we_b |-> o_pins.dq_oe && !o_pins.ce_b)
    else $error("write strobe without driven data or select");
  a_read_float: assert property (!o_pins.oe_b |-> !o_pins.dq_oe && !o_pins.ce_b)
    else $error("read strobe while host drives data");
  // the part latches the address at the falling strobe edge and the data at the rising one
  a_write_stable: assert property (!o_pins.we_b && $past(o_pins.we_b) == 1'b0 |->
    $stable(o_pins.addr) && $stable(o_pins.dq_o))
    else $error("address or data moved during write strobe");
  a_write_width: assert property ($fell(o_pins.we_b) |-> !o_pins.we_b [*4])
    else $error("write strobe shorter than four cycles");
  a_read_width: assert property ($fell(o_pins.oe_b) |-> !o_pins.oe_b [*7])
    else $error("read strobe shorter than access time");
  a_setup_time: assert property ($fell(o_pins.we_b) |-> $past(o_pins.ce_b, 3) == 1'b0)
    else $error("write strobe without select setup");
  // unlock addresses only make sense with the matching width pin
  a_byte_pin: assert property (!o_pins.ce_b |-> o_pins.byte_b == !i_byte_mode)
    else $error("width pin disagrees with byte mode");
endmodule

bind fcd_host fcd_host_asserts u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
  .i_byte_mode(i_byte_mode), .o_pins(o_pins));

/* fcd_flash_model.sv */
/* fcd_flash_model: behavioural nor flash decoding the host's pin sequences.
   assumes: pins from fcd_host; a released bus shows inverted old data. */
module fcd_flash_model
  import fcd_pkg::*;
#(
  parameter int DLY = 60, // access delay, inside the host read pulse
  parameter logic [15:0] MAKER = 16'h00A5, // arbitrary value
  parameter logic [15:0] DEV = 16'h5A3C, // arbitrary value
  parameter logic [5:0] PROT = 6'h05 // the protected sector
)(
  // pins from the host
  input wire fcd_pins_t i_pins,
  // data back to the host
  output logic [15:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:262143]; // whole array
  logic [17:0] a_q = '0; // latched write address
  logic [15:0] dq = '0;
  logic [15:0] last = '0;
  logic asel = 1'b0, byp = 1'b0, ers = 1'b0, sus = 1'b0; // modes
  int stp = 0; // place in the command sequence
  wire logic [10:0] u1 = i_pins.byte_b ? FCD_UNL1_W[10:0] : FCD_UNL1_B[10:0];
  wire logic [10:0] u2 = i_pins.byte_b ? FCD_UNL2_W[10:0] : FCD_UNL2_B[10:0];
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  ////////////////////////////////////////////////////////////
  // one decoded write; sector erase clears the sector at once and ends only at resume or when reset_b falls, to keep the model short
  task automatic wr(input logic [17:0] a, input logic [15:0] dw);
    logic [7:0] d;
    d = dw[7:0]; // upper byte ignored for commands, used as program data
    if (ers && !sus) begin
      if (d == FCD_D_SUSP) sus = 1'b1;
    end else if (stp == 6) begin
      mem[a] = mem[a] & dw; // programming only clears bits
      stp = 0;
    end else if (byp) begin
      if (stp == 7 && d == FCD_D_BYPX) byp = 1'b0;
      stp = (d == FCD_D_PROG) ? 6 : (d == FCD_D_ASEL && stp != 7) ? 7 : 0;
    end else if (d == FCD_D_RESET) begin
      stp = 0;
      asel = 1'b0;
    end else if (stp == 0 && sus && d == FCD_D_RESUME) begin
      sus = 1'b0;
      ers = 1'b0;
    end else if ((stp == 0 || stp == 3) && d == FCD_D_AA && a[10:0] == u1) stp++;
    else if ((stp == 1 || stp == 4) && d == FCD_D_55 && a[10:0] == u2) stp++;
    else if (stp == 2 && a[10:0] == u1 && d == FCD_D_ESET && !sus) stp = 3;
    else if (stp == 2 && a[10:0] == u1) begin
      asel = (d == FCD_D_ASEL);
      byp = (d == FCD_D_BYP) && !sus;
      stp = (d == FCD_D_PROG) ? 6 : 0;
    end else if (stp == 5 && d == FCD_D_CERS && a[10:0] == u1) begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      stp = 0;
    end else if (stp == 5 && d == FCD_D_SERS) begin
      for (int i = 0; i < 4096; i++) mem[{a[17:12], i[11:0]}] = 16'hFFFF;
      ers = 1'b1;
      stp = 0;
    end else stp = 0; // broken pattern back to step 0, modes kept
  endtask
  function automatic logic [15:0] rdv(input logic [17:0] a);
    if (!asel) return mem[a]; // plain single read
    if (a[11:0] == 12'h000) return MAKER;
    if (a[11:0] == (i_pins.byte_b ? FCD_AS_DEV_W[11:0] : FCD_AS_DEV_B[11:0])) return DEV;
    if (a[11:0] == (i_pins.byte_b ? FCD_AS_PROT_W[11:0] : FCD_AS_PROT_B[11:0]))
      return {15'h0000, a[17:12] == PROT};
    return 16'h0000;
  endfunction
  ////////////////////////////////////////////////////////////
  // address on the falling strobe, data on the rising one
  always @(negedge i_pins.we_b) a_q = i_pins.addr;
  always @(posedge i_pins.we_b) if (!i_pins.ce_b && i_pins.reset_b) wr(a_q, i_pins.dq_o);
  always @(negedge i_pins.reset_b) begin
    stp = 0;
    asel = 1'b0;
    byp = 1'b0;
    ers = 1'b0;
    sus = 1'b0;
  end
  // a released bus must not look like valid data
  always @* begin
    if (!i_pins.ce_b && !i_pins.oe_b) begin
      dq = rdv(i_pins.addr);
      last = dq;
    end else dq = ~last;
  end
  assign #DLY o_dq = dq;
endmodule

/* tb_top.sv */
/* tb_top: random and corner-case requests through fcd_host into a flash model.
   assumes: the checker binds itself; inputs change on the falling edge. */
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
  import fcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] PROT = 6'h05; // protected sector
  localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
  localparam logic [15:0] DEV = 16'h5A3C; // arbitrary value
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_req_valid = 1'b0, i_byte_mode = 1'b0, i_erasing = 1'b0;
  fcd_req_t i_req = '0;
  wire logic o_req_ready, o_rd_valid, o_in_bypass, o_in_suspend;
  wire logic [15:0] o_rd_data, i_dq;
  wire fcd_pins_t o_pins;
  int err_count = 0, n_checks = 0, cyc = 0;
  logic [31:0] seed = 32'h0000_F0E1; // fixed seed
  logic [15:0] rd = '0; // last read data
  logic [15:0] ref_m [logic [17:0]]; // expected array
  logic [17:0] a;
  logic seen = 1'b0; // read data pulse seen in the last request
  int t0 = 0; // cycle count before a request, to spot refused ones
  fcd_host DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_req_valid(i_req_valid),
    .i_req(i_req), .i_byte_mode(i_byte_mode), .i_erasing(i_erasing),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_in_bypass(o_in_bypass), .o_in_suspend(o_in_suspend), .i_dq(i_dq), .o_pins(o_pins));
  fcd_flash_model #(.MAKER(MAKER), .DEV(DEV), .PROT(PROT)) FM (.i_pins(o_pins), .o_dq(i_dq));
  ////////////////////////////////////////////////////////////
  always #5 i_mclk = ~i_mclk;
  // hang guard, well above the few thousand cycles needed
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_rd(input logic [17:0] x);
    return ref_m.exists(x) ? ref_m[x] : 16'hFFFF;
  endfunction
  // hold the request until taken, then wait for idle, catching read data
  task automatic req(input fcd_op_t op, input logic [17:0] ad, input logic [15:0] dt);
    @(negedge i_mclk);
    i_req_valid = 1'b1;
    i_req = '{op, ad, dt};
    seen = 1'b0;
    while (o_req_ready !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    while (o_req_ready !== 1'b1) begin
      if (o_rd_valid === 1'b1) begin
        rd = o_rd_data;
        seen = 1'b1;
      end
      @(negedge i_mclk);
    end
    if (op == FCD_OP_READ || op == FCD_OP_ASEL) `CHK(seen, 1'b1)
    else `CHK(seen, 1'b0)
  endtask
  task automatic prog(input logic byp_on, input logic [17:0] ad, input logic [15:0] dt);
    req(byp_on ? FCD_OP_BYP_PROG : FCD_OP_PROG, ad, dt);
    ref_m[ad] = exp_rd(ad) & dt;
    req(FCD_OP_READ, ad, 16'h0000);
    `CHK(rd, exp_rd(ad))
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge i_mclk);
    i_rst_b = 1'b1;
    req(FCD_OP_CHIP_ERASE, 18'h0_0000, 16'h0000);
    a = 18'(rnd());
    req(FCD_OP_READ, a, 16'h0000);
    `CHK(rd, 16'hFFFF)
    prog(1'b0, 18'h3_FFFF, 16'h0000);
    repeat (8) begin
      i_byte_mode = seed[7];
      prog(1'b0, 18'(rnd()), 16'(rnd()));
    end
    // identification codes and protect verify in both widths
    for (int m = 0; m < 2; m++) begin
      i_byte_mode = m[0];
      req(FCD_OP_ASEL, 18'h0_0000, 16'h0000);
      `CHK(rd, MAKER)
      req(FCD_OP_ASEL, m ? FCD_AS_DEV_B : FCD_AS_DEV_W, 16'h0000);
      `CHK(rd, DEV)
      for (int s = 4; s < 7; s++) begin
        req(FCD_OP_ASEL, (m ? FCD_AS_PROT_B : FCD_AS_PROT_W) | {s[5:0], 12'h000}, 16'h0000);
        `CHK(rd, {15'h0000, s[5:0] == PROT})
      end
      req(FCD_OP_RESET, a, 16'h0000);
      req(FCD_OP_READ, a, 16'h0000);
      `CHK(rd, exp_rd(a))
    end
    // bypass: short programs, a refused full program, then exit
    req(FCD_OP_BYP_ENTER, a, 16'h0000);
    `CHK({o_in_bypass, FM.byp}, 2'b11)
    repeat (3) prog(1'b1, 18'(rnd()), 16'(rnd()));
    t0 = cyc;
    req(FCD_OP_PROG, a, 16'h0000);
    `CHK({o_in_bypass, FM.stp == 0}, 2'b11)
    `CHK(cyc - t0 < 8, 1'b1)
    req(FCD_OP_BYP_EXIT, a, 16'h0000);
    `CHK({o_in_bypass, FM.byp}, 2'b00)
    // a suspend with no erase running is neither sent nor tracked
    req(FCD_OP_SUSPEND, a, 16'h0000);
    `CHK(o_in_suspend, 1'b0)
    // sector erase, suspend, program another sector, resume
    a = 18'(rnd());
    prog(1'b0, a, 16'h1234);
    req(FCD_OP_SECT_ERASE, a, 16'h0000);
    foreach (ref_m[k]) if (k[17:12] == a[17:12]) ref_m[k] = 16'hFFFF;
    i_erasing = 1'b1;
    t0 = cyc;
    req(FCD_OP_PROG, a, 16'h0000);
    `CHK(cyc - t0 < 8, 1'b1)
    req(FCD_OP_SUSPEND, a, 16'h0000);
    i_erasing = 1'b0;
    `CHK({o_in_suspend, FM.sus}, 2'b11)
    // a short program outside bypass mode is refused
    t0 = cyc;
    req(FCD_OP_BYP_PROG, a, 16'h0000);
    `CHK(cyc - t0 < 8, 1'b1)
    prog(1'b0, a ^ 18'h1_0000, 16'(rnd()));
    req(FCD_OP_READ, a, 16'h0000);
    `CHK(rd, 16'hFFFF)
    req(FCD_OP_RESUME, a, 16'h0000);
    `CHK({o_in_suspend, FM.sus}, 2'b00)
    // reset in the middle of a bypass program
    req(FCD_OP_BYP_ENTER, a, 16'h0000);
    @(negedge i_mclk);
    i_req_valid = 1'b1;
    i_req = '{FCD_OP_BYP_PROG, a, 16'h0000};
    repeat (6) @(negedge i_mclk);
    i_rst_b = 1'b0;
    i_req_valid = 1'b0;
    @(negedge i_mclk);
    `CHK({o_in_bypass, o_pins.reset_b, FM.byp}, 3'b000)
    i_rst_b = 1'b1;
    req(FCD_OP_READ, a, 16'h0000);
    `CHK(rd, exp_rd(a))
    conclude();
  end
endmodule
